// File: rtl/psi_status_irq_regs.v
/*
  Status, interrupt mask and change-flag registers of a 10/100 PHY,
  reached over the serial management pins (clock and two-way data).
  Assumes the management clock is far slower than clk_in, so each of
  its rising edges is found by sampling, and that status inputs are
  levels from other domains.
*/
`timescale 1ns/10ps
`include "psi_consts.vh"
module psi_status_irq_regs #(
  parameter [4:0] PHY_ADDR = 5'h00
) (
  // clock and reset
  input  wire clk_in,
  input  wire sys_rst_in,
  // management pins
  input  wire mgmt_clk_in,
  input  wire mdio_in,
  output reg  mdio_out,
  output reg  mdio_oe_out,
  output reg  mgmt_irq_out_n,
  // resolved link state from the transceiver core
  input  wire full_duplex_in,
  input  wire an_mode_in,
  input  wire an_complete_in,
  input  wire polarity_rev_in,
  input  wire pause_capable_in,
  input  wire speed_100_in,
  input  wire link_up_in,
  // error sources
  input  wire remote_fault_in,
  input  wire jabber_in,
  input  wire pd_fault_in
);

  // ---------------------------------------------------------------
  // state encodings
  // ---------------------------------------------------------------
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_HDR   = 4'b0010;
  localparam [3:0] ST_READ  = 4'b0100;
  localparam [3:0] ST_WRITE = 4'b1000;

  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  wire [11:0] sync_q;
  wire        mdc_s;
  wire        mdio_s;
  wire        duplex_s;
  wire        an_mode_s;
  wire        an_cmp_s;
  wire        polarity_s;
  wire        pause_s;
  wire        speed_s;
  wire        link_s;
  wire        remote_s;
  wire        jabber_s;
  wire        pdf_s;

  psi_sync #(
    .WIDTH (12)
  ) u_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({mgmt_clk_in, mdio_in, full_duplex_in, an_mode_in,
                  an_complete_in, polarity_rev_in, pause_capable_in,
                  speed_100_in, link_up_in, remote_fault_in,
                  jabber_in, pd_fault_in}),
    .sync_out   (sync_q)
  );

  assign mdc_s      = sync_q[11];
  assign mdio_s     = sync_q[10];
  assign duplex_s   = sync_q[9];
  assign an_mode_s  = sync_q[8];
  assign an_cmp_s   = sync_q[7];
  assign polarity_s = sync_q[6];
  assign pause_s    = sync_q[5];
  assign speed_s    = sync_q[4];
  assign link_s     = sync_q[3];
  assign remote_s   = sync_q[2];
  assign jabber_s   = sync_q[1];
  assign pdf_s      = sync_q[0];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg        mdc_prev;
  reg [3:0]  state;
  reg [5:0]  pre_cnt;
  reg [3:0]  hdr_cnt;
  reg [12:0] hdr_sr;
  reg [4:0]  dat_cnt;
  reg [4:0]  wr_reg;
  reg [15:0] rd_sr;
  reg [15:0] wr_sr;
  reg [3:0]  evt_mask;
  reg        irq_global_enable;
  reg        test_irq_force;
  reg [3:0]  chg_flag;
  reg        error_flag;
  reg        status_primed;
  reg        prev_an_cmp;
  reg        prev_speed;
  reg        prev_duplex;
  reg        prev_link;

  // ---------------------------------------------------------------
  // frame decode
  // ---------------------------------------------------------------
  wire        mdc_rise;
  wire [13:0] hdr_word;
  wire        hdr_done;
  wire        hdr_ours;
  wire        rd_hit;
  wire        wr_hit;
  wire        flag_clr;
  wire        err_clr;
  wire [15:0] wr_word;

  // the first bit of start is the zero that ends the preamble
  assign mdc_rise = mdc_s & ~mdc_prev;
  assign hdr_word = {hdr_sr, mdio_s};
  assign hdr_done = mdc_rise & state[1] & (hdr_cnt == `PSI_HDR_LAST);
  assign hdr_ours = hdr_done & (hdr_word[13:12] == `PSI_FRAME_START) &
                    (hdr_word[9:5] == PHY_ADDR);
  assign rd_hit   = hdr_ours & (hdr_word[11:10] == `PSI_OP_READ);
  assign wr_hit   = hdr_ours & (hdr_word[11:10] == `PSI_OP_WRITE);
  assign wr_word  = {wr_sr[14:0], mdio_s};

  // flags are captured and cleared in the very cycle the frame
  // commits to a read of them
  assign flag_clr = rd_hit &
                    (hdr_word[4:0] == `PSI_REG_EVENT_FLAGS);
  // reading either error source register releases the error bit
  assign err_clr  = rd_hit &
                    ((hdr_word[4:0] == `PSI_REG_BASIC_STATUS) |
                     (hdr_word[4:0] == `PSI_REG_AN_EXPANSION));

  // ---------------------------------------------------------------
  // events and interrupt request
  // ---------------------------------------------------------------
  wire [3:0] evt;
  wire [3:0] next_chg_flag;
  wire       err_cond;
  wire       next_error_flag;
  wire       irq_req;

  // first sample after reset only primes the history
  assign evt[3] = status_primed & an_cmp_s & ~prev_an_cmp;
  assign evt[2] = status_primed & (speed_s ^ prev_speed);
  assign evt[1] = status_primed & (duplex_s ^ prev_duplex);
  assign evt[0] = status_primed & (link_s ^ prev_link);

  // a new event wins over the read clear
  assign next_chg_flag = evt | (chg_flag & ~{4{flag_clr}});

  assign err_cond        = remote_s | jabber_s | pdf_s;
  assign next_error_flag = err_cond | (error_flag & ~err_clr);

  // mask bits line up with flag bits: done, speed, duplex, link
  assign irq_req = test_irq_force |
                   (irq_global_enable &
                    |(chg_flag & evt_mask));

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  reg [15:0] rd_word;

  always @* begin
    rd_word = 16'h0000;
    case (hdr_word[4:0])
      `PSI_REG_STATUS_TWO: begin
        rd_word[`PSI_ST2_DUPLEX]   = duplex_s;
        rd_word[`PSI_ST2_AN_MODE]  = an_mode_s;
        rd_word[`PSI_ST2_AN_DONE]  = an_cmp_s;
        rd_word[`PSI_ST2_POLARITY] = polarity_s;
        rd_word[`PSI_ST2_PAUSE]    = pause_s;
        rd_word[`PSI_ST2_ERROR]    = error_flag;
      end
      `PSI_REG_IRQ_MASK: begin
        // reserved bits are not stored and read as zero
        rd_word[`PSI_MSK_AN_DONE] = evt_mask[3];
        rd_word[`PSI_MSK_SPEED]   = evt_mask[2];
        rd_word[`PSI_MSK_DUPLEX]  = evt_mask[1];
        rd_word[`PSI_MSK_LINK]    = evt_mask[0];
        rd_word[`PSI_MSK_GLOBAL]  = irq_global_enable;
        rd_word[`PSI_MSK_FORCE]   = test_irq_force;
      end
      `PSI_REG_EVENT_FLAGS: begin
        rd_word[`PSI_FLG_AN_DONE] = chg_flag[3];
        rd_word[`PSI_FLG_SPEED]   = chg_flag[2];
        rd_word[`PSI_FLG_DUPLEX]  = chg_flag[1];
        rd_word[`PSI_FLG_LINK]    = chg_flag[0];
        rd_word[`PSI_FLG_PENDING] = irq_req;
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  wire rd_ours;

  // only the three registers of this block drive the data pin
  assign rd_ours = (hdr_word[4:0] == `PSI_REG_STATUS_TWO) |
                   (hdr_word[4:0] == `PSI_REG_IRQ_MASK) |
                   (hdr_word[4:0] == `PSI_REG_EVENT_FLAGS);

  // ---------------------------------------------------------------
  // status history and sticky flags
  // ---------------------------------------------------------------
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      status_primed <= 1'b0;
      prev_an_cmp   <= 1'b0;
      prev_speed    <= 1'b0;
      prev_duplex   <= 1'b0;
      prev_link     <= 1'b0;
      chg_flag      <= `PSI_FLAGS_RST;
      error_flag    <= 1'b0;
    end else begin
      status_primed <= 1'b1;
      prev_an_cmp   <= an_cmp_s;
      prev_speed    <= speed_s;
      prev_duplex   <= duplex_s;
      prev_link     <= link_s;
      chg_flag      <= next_chg_flag;
      error_flag    <= next_error_flag;
    end
  end

  // ---------------------------------------------------------------
  // interrupt output
  // ---------------------------------------------------------------
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      mgmt_irq_out_n <= 1'b1;
    end else begin
      mgmt_irq_out_n <= ~irq_req;
    end
  end

  // ---------------------------------------------------------------
  // mask register writes
  // ---------------------------------------------------------------
  wire wr_commit;

  assign wr_commit = mdc_rise & state[3] & (dat_cnt == `PSI_DATA_LAST) &
                     (wr_reg == `PSI_REG_IRQ_MASK);

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      evt_mask          <= `PSI_EVT_MASK_RST;
      irq_global_enable <= 1'b0;
      test_irq_force    <= 1'b0;
    end else if (wr_commit) begin
      // reserved bits are dropped, so stray ones cannot steer anything
      evt_mask[3]       <= wr_word[`PSI_MSK_AN_DONE];
      evt_mask[2]       <= wr_word[`PSI_MSK_SPEED];
      evt_mask[1]       <= wr_word[`PSI_MSK_DUPLEX];
      evt_mask[0]       <= wr_word[`PSI_MSK_LINK];
      irq_global_enable <= wr_word[`PSI_MSK_GLOBAL];
      test_irq_force    <= wr_word[`PSI_MSK_FORCE];
    end
  end

  // ---------------------------------------------------------------
  // management frame engine
  // ---------------------------------------------------------------
  // data is sampled and driven just after each sampled rising edge;
  // the sampling delay is a few clk_in cycles, well inside the
  // management clock's half period
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      mdc_prev    <= 1'b0;
      state       <= ST_IDLE;
      pre_cnt     <= 6'd0;
      hdr_cnt     <= 4'd0;
      hdr_sr      <= 13'h0000;
      dat_cnt     <= 5'd0;
      wr_reg      <= 5'h00;
      rd_sr       <= 16'h0000;
      wr_sr       <= 16'h0000;
      mdio_out    <= 1'b0;
      mdio_oe_out <= 1'b0;
    end else begin
      mdc_prev <= mdc_s;
      if (mdc_rise) begin
        case (state)
          ST_IDLE: begin
            if (mdio_s) begin
              if (pre_cnt != `PSI_PREAMBLE_BITS) begin
                pre_cnt <= pre_cnt + 6'd1;
              end
            end else begin
              if (pre_cnt == `PSI_PREAMBLE_BITS) begin
                state   <= ST_HDR;
                hdr_sr  <= 13'h0000;
                hdr_cnt <= 4'd1;
              end
              pre_cnt <= 6'd0;
            end
          end
          ST_HDR: begin
            hdr_sr  <= hdr_word[12:0];
            hdr_cnt <= hdr_cnt + 4'd1;
            if (hdr_done) begin
              dat_cnt <= 5'd0;
              pre_cnt <= 6'd0;
              if (rd_hit && rd_ours) begin
                state <= ST_READ;
                rd_sr <= rd_word;
              end else if (wr_hit) begin
                state  <= ST_WRITE;
                wr_reg <= hdr_word[4:0];
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_READ: begin
            dat_cnt <= dat_cnt + 5'd1;
            if (dat_cnt == 5'd0) begin
              // second turnaround bit: device drives zero
              mdio_oe_out <= 1'b1;
              mdio_out    <= 1'b0;
            end else if (dat_cnt == `PSI_DATA_LAST) begin
              mdio_oe_out <= 1'b0;
              mdio_out    <= 1'b0;
              state       <= ST_IDLE;
            end else begin
              mdio_out <= rd_sr[15];
              rd_sr    <= {rd_sr[14:0], 1'b0};
            end
          end
          ST_WRITE: begin
            dat_cnt <= dat_cnt + 5'd1;
            wr_sr   <= wr_word;
            if (dat_cnt == `PSI_DATA_LAST) begin
              state <= ST_IDLE;
            end
          end
          default: begin
            state       <= ST_IDLE;
            mdio_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // psi_status_irq_regs

// File: rtl/psi_consts.vh
/*
  Constants for the PHY status and interrupt register block: management
  register addresses, field positions, reset values and frame counts.
  Assumes it is included by bare name from the design files.
*/
`ifndef PSI_CONSTS_VH
`define PSI_CONSTS_VH

// register addresses on the management bus
`define PSI_REG_BASIC_STATUS  5'h01
`define PSI_REG_AN_EXPANSION  5'h06
`define PSI_REG_STATUS_TWO    5'h11
`define PSI_REG_IRQ_MASK      5'h12
`define PSI_REG_EVENT_FLAGS   5'h13

// phy_status_two field positions
`define PSI_ST2_DUPLEX        9
`define PSI_ST2_AN_MODE       8
`define PSI_ST2_AN_DONE       7
`define PSI_ST2_POLARITY      5
`define PSI_ST2_PAUSE         4
`define PSI_ST2_ERROR         3

// irq_mask_enable field positions
`define PSI_MSK_AN_DONE       7
`define PSI_MSK_SPEED         6
`define PSI_MSK_DUPLEX        5
`define PSI_MSK_LINK          4
`define PSI_MSK_GLOBAL        1
`define PSI_MSK_FORCE         0

// event_change_flags field positions
`define PSI_FLG_AN_DONE       7
`define PSI_FLG_SPEED         6
`define PSI_FLG_DUPLEX        5
`define PSI_FLG_LINK          4
`define PSI_FLG_PENDING       2

// reset values
`define PSI_EVT_MASK_RST      4'h0
`define PSI_FLAGS_RST         4'h0

// management frame fields and counts
`define PSI_PREAMBLE_BITS     6'd32
`define PSI_HDR_LAST          4'd13
`define PSI_FRAME_START       2'b01
`define PSI_OP_READ           2'b10
`define PSI_OP_WRITE          2'b01
`define PSI_DATA_LAST         5'd17
`define PSI_DATA_FIRST        5'd1

`endif

// File: rtl/psi_sync.v
/*
  Two-flop synchroniser for a vector of independent levels.
  Assumes each bit is a slow level or a clock far slower than clk_in;
  bits are not kept coherent with one another.
*/
`timescale 1ns/10ps
module psi_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clk_in,
  input  wire             sys_rst_in,
  // asynchronous levels in, synchronised levels out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // psi_sync

// File: sim/psi_checker_sva.sv
/*
  Checker for the status and interrupt register block: frame timing
  of the data wire and causes of interrupt output changes.
  Assumes it is bound to the top module and that the management clock
  is far slower than clk_in.
*/
`timescale 1ns/10ps
module psi_checker_sva (
  // clock and reset
  input logic clk_in,
  input logic sys_rst_in,
  // management pins
  input logic mgmt_clk_in,
  input logic mdio_out,
  input logic mdio_oe_out,
  input logic mgmt_irq_out_n,
  // event sources
  input logic full_duplex_in,
  input logic an_complete_in,
  input logic speed_100_in,
  input logic link_up_in
);
  logic       mc_q;
  logic [3:0] st_q;
  logic [7:0] since_mc;
  logic [7:0] since_st;
  logic [4:0] oe_edges;
  wire        mc_rise = mgmt_clk_in & ~mc_q;
  wire  [3:0] st_now  = {full_duplex_in, an_complete_in, speed_100_in,
                         link_up_in};

  // cycle counts since the last management edge and status change
  always_ff @(posedge clk_in) begin
    mc_q <= mgmt_clk_in;
    st_q <= st_now;
    if (sys_rst_in || mc_rise)
      since_mc <= sys_rst_in ? 8'hFF : 8'h00;
    else if (since_mc != 8'hFF)
      since_mc <= since_mc + 8'h01;
    if (st_now != st_q)
      since_st <= 8'h00;
    else if (since_st != 8'hFF)
      since_st <= since_st + 8'h01;
    if (!mdio_oe_out)
      oe_edges <= 5'h00;
    else if (mc_rise)
      oe_edges <= oe_edges + 5'h01;
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_rst_quiet: assert property (disable iff (1'b0)
    sys_rst_in |=> mgmt_irq_out_n && !mdio_oe_out)
    else $error("interrupt or data drive active after reset");
  a_ta_zero: assert property ($rose(mdio_oe_out) |-> !mdio_out)
    else $error("turnaround bit not driven low");
  a_oe_start: assert property ($rose(mdio_oe_out) |-> since_mc <= 8'd8)
    else $error("data drive starts away from a clock edge");
  a_oe_length: assert property (
    $fell(mdio_oe_out) && !$past(sys_rst_in) |-> oe_edges == 5'd17)
    else $error("read drive does not span 17 clock edges");
  a_oe_stop: assert property ($fell(mdio_oe_out) |-> since_mc <= 8'd8)
    else $error("data drive released away from a clock edge");
  a_out_timing: assert property (
    mdio_oe_out && $changed(mdio_out) |-> since_mc <= 8'd8)
    else $error("read bit changed away from a clock edge");
  a_oe_idle: assert property (mdio_oe_out |-> since_mc <= 8'd12)
    else $error("data driven while management clock idle");
  a_irq_fall: assert property ($fell(mgmt_irq_out_n) |->
    since_mc <= 8'd8 || since_st <= 8'd8)
    else $error("interrupt asserted without a cause");
  a_irq_rise: assert property (
    $rose(mgmt_irq_out_n) && !$past(sys_rst_in) |-> since_mc <= 8'd8)
    else $error("interrupt released without an access");
endmodule // psi_checker_sva

// File: sim/psi_mgmt_model.sv
/*
  Station management model: sends management frames on the clock and
  data lines. Assumes the bench resolves the wire with a pull-up.
*/
`timescale 1ns/10ps
module psi_mgmt_model #(
  parameter logic [4:0] PHY = 5'h05
) (
  // wire level seen at the pin
  input  wire logic mdio_in,
  // driven lines
  output logic      mgmt_clk_out,
  output logic      mdio_drv_out,
  output logic      mdio_en_out
);
  initial begin
    mgmt_clk_out = 1'b0;
    mdio_drv_out = 1'b1;
    mdio_en_out  = 1'b0;
  end

  // clock stands still low between frames; data released after header on reads
  task automatic xfer(input int npre, input logic [1:0] op,
                      input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [31:0] hdr;
    int          i;
    hdr = {2'b01, op, PHY, ra, 2'b10, wd};
    rd  = 16'h0000;
    for (i = 0; i < npre + 32; i++) begin
      mgmt_clk_out = 1'b0;
      mdio_en_out  = (op == 2'b01) || (i < npre + 14);
      mdio_drv_out = (i < npre) ? 1'b1 : hdr[31 - (i - npre)];
      #24;
      mgmt_clk_out = 1'b1;
      rd = {rd[14:0], mdio_in};
      #24;
    end
    mgmt_clk_out = 1'b0;
    mdio_en_out  = 1'b0;
  endtask
endmodule // psi_mgmt_model

// File: sim/testbench.sv
/*
  Testbench for the status and interrupt registers, checked against a
  reference model. Assumes a 200 MHz clock and a pulled-up data wire.
*/
`timescale 1ns/10ps
module testbench;
  logic        clk_in, sys_rst_in, fd, anm, anc, pol, pau, spd, lnk;
  logic        rf, jab, pdf, exp_err;
  wire         mdc, m_d, m_en, d_out, d_oe, irq_n;
  wire         mdio_w = d_oe ? d_out : (m_en ? m_d : 1'b1);
  int          n_mismatch, n_compared, i, k;
  logic [31:0] rng;
  logic [15:0] rd, w, b, exp_msk, exp_flg;

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  psi_status_irq_regs #(.PHY_ADDR(5'h05)) u_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .mgmt_clk_in(mdc),
    .mdio_in(mdio_w), .mdio_out(d_out), .mdio_oe_out(d_oe),
    .mgmt_irq_out_n(irq_n), .full_duplex_in(fd), .an_mode_in(anm),
    .an_complete_in(anc), .polarity_rev_in(pol),
    .pause_capable_in(pau), .speed_100_in(spd), .link_up_in(lnk),
    .remote_fault_in(rf), .jabber_in(jab), .pd_fault_in(pdf));
  psi_mgmt_model #(.PHY(5'h05)) u_mgmt (.mdio_in(mdio_w),
    .mgmt_clk_out(mdc), .mdio_drv_out(m_d), .mdio_en_out(m_en));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic pend();
    return exp_msk[0] | (exp_msk[1] & |(exp_flg[7:4] & exp_msk[7:4]));
  endfunction
  function automatic logic [15:0] st2();
    return {6'h00, fd, anm, anc, 1'b0, pol, pau, exp_err, 3'h0};
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic rdr(input logic [4:0] ra);
    u_mgmt.xfer(32, 2'b10, ra, 16'h0000, rd);
  endtask
  task automatic wrr(input logic [15:0] d);
    u_mgmt.xfer(32, 2'b01, 5'h12, d & 16'h00F3, rd);
    exp_msk = d & 16'h00F3;
    wt(8);
  endtask
  task automatic rdf();
    logic [15:0] e;
    e = exp_flg | {13'h0000, pend(), 2'b00};
    rdr(5'h13);
    chk("event_change_flags", rd, e);
    exp_flg = 16'h0000;
    wt(8);
  endtask
  // one change of the event source k, flag bit 7-k
  task automatic ev(input int k);
    if (k == 0) begin
      anc = 1'b0;
      wt(8);
      anc = 1'b1;
    end else if (k == 1)
      spd = ~spd;
    else if (k == 2)
      fd = ~fd;
    else
      lnk = ~lnk;
    exp_flg[7-k] = 1'b1;
    wt(10);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #400000;
    n_mismatch++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst_in = 1'b1;
    {fd, anm, anc, pol, pau, spd, lnk, rf, jab, pdf} = 10'h000;
    n_mismatch = 0;
    n_compared = 0;
    rng = 32'had483b0f;
    exp_err = 1'b0;
    exp_msk = 16'h0000;
    exp_flg = 16'h0000;
    wt(10);
    sys_rst_in = 1'b0;
    wt(4);
    chk("irq_reset", {15'h0, irq_n}, 16'h0001);
    rdr(5'h12);
    chk("mask_reset", rd, 16'h0000);
    for (i = 0; i < 6; i++) begin
      rng = xs(rng);
      wt(1);
      exp_flg[5] = exp_flg[5] | (fd ^ rng[4]);
      exp_flg[7] = exp_flg[7] | (rng[2] & ~anc);
      {fd, anm, anc, pol, pau} = rng[4:0];
      wt(8);
      rdr(5'h11);
      chk("phy_status_two", rd, st2());
    end
    rdf();
    for (k = 0; k < 3; k++) begin
      {rf, jab, pdf} = 3'b100 >> k;
      wt(6);
      {rf, jab, pdf} = 3'b000;
      exp_err = 1'b1;
      wt(6);
      rdr(5'h11);
      chk("error_set", rd, st2());
      rdr(k[0] ? 5'h06 : 5'h01);
      chk("unmapped_read", rd, 16'hFFFF);
      exp_err = 1'b0;
      rdr(5'h11);
      chk("error_clear", rd, st2());
      wt(1);
    end
    for (i = 0; i < 4; i++) begin
      rng = xs(rng);
      w = (i == 0) ? 16'hFFFF : rng[15:0];
      wrr(w);
      chk("irq_force", {15'h0, irq_n}, {15'h0, ~pend()});
      rdr(5'h12);
      chk("irq_mask_enable", rd, exp_msk);
      rdf();
    end
    u_mgmt.xfer(31, 2'b10, 5'h12, 16'h0000, rd);
    chk("short_preamble", rd, 16'hFFFF);
    for (k = 0; k < 4; k++) begin
      b = 16'h0080 >> k;
      for (i = 0; i < 3; i++) begin
        wrr(i == 0 ? b : (i == 1 ? b | 16'h0002 : 16'h00F2 ^ b));
        ev(k);
        chk("irq_event", {15'h0, irq_n}, {15'h0, ~pend()});
        rdf();
        chk("irq_read", {15'h0, irq_n}, {15'h0, ~pend()});
      end
    end
    stop_test();
  end
endmodule // testbench

bind psi_status_irq_regs psi_checker_sva u_chk (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .mgmt_clk_in(mgmt_clk_in),
  .mdio_out(mdio_out), .mdio_oe_out(mdio_oe_out),
  .mgmt_irq_out_n(mgmt_irq_out_n), .full_duplex_in(full_duplex_in),
  .an_complete_in(an_complete_in), .speed_100_in(speed_100_in),
  .link_up_in(link_up_in));
